/* hw/phc_pkg.sv */
package phc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] DELAY_SHARE_SOFTSTART_CFG_OFS = 8'h10;
    localparam logic [7:0] PROTECTION_POLARITY_CFG_OFS   = 8'h11;
    localparam logic [7:0] HOUSEKEEPING_STATUS_OFS       = 8'h18;
    localparam logic [7:0] CFG_RESET                     = 8'h00;
    localparam logic [7:0] RDATA_UNMAPPED                = 8'h00;
    localparam logic [7:0] PROT_CFG_WMASK                = 8'he7;

    // ------------------------------------------------------------
    // field positions, delay/share/soft-start register
    // ------------------------------------------------------------
    localparam int OFF_DELAY_LSB  = 6;
    localparam int SHARE_CAP_LSB  = 4;
    localparam int SOFT_START_LSB = 2;
    localparam int ADDR_BIT_POS   = 1;
    localparam int TRIM_LOCK_POS  = 0;

    // ------------------------------------------------------------
    // field positions, protection/polarity register
    // ------------------------------------------------------------
    localparam int OC_MASK_POS    = 7;
    localparam int PEN_POL_POS    = 6;
    localparam int BRK_POL_POS    = 5;
    localparam int ZERO_RIDE_POS  = 2;
    localparam int GND_DIS_POS    = 1;
    localparam int BRK_LATCH_POS  = 0;

    // ------------------------------------------------------------
    // pin-5 function codes
    // ------------------------------------------------------------
    localparam logic [2:0] FN_MAINS_LO = 3'h0;
    localparam logic [2:0] FN_MAINS_HI = 3'h1;
    localparam logic [2:0] FN_POS_OV   = 3'h2;
    localparam logic [2:0] FN_POS_UV   = 3'h3;
    localparam logic [2:0] FN_NEG_OV   = 3'h4;
    localparam logic [2:0] FN_NEG_UV   = 3'h5;
    localparam logic [2:0] FN_FLAG     = 3'h6;

    // ------------------------------------------------------------
    // synchroniser bit positions
    // ------------------------------------------------------------
    localparam int SYN_W     = 5;
    localparam int SYN_PIN5  = 0;
    localparam int SYN_MAINS = 1;
    localparam int SYN_PSON  = 2;
    localparam int SYN_OC    = 3;
    localparam int SYN_GND   = 4;

    // ------------------------------------------------------------
    // times in their own units
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 10;
    localparam int PSON_DB0_MS    = 80;
    localparam int PSON_DB2_MS    = 40;
    localparam int PSON_DB3_MS    = 160;
    localparam int OFF_WARN0_MS   = 2;
    localparam int OFF_WARN1_MS   = 0;
    localparam int OFF_WARN2_MS   = 1;
    localparam int OFF_WARN3_MS   = 4;
    localparam int SS_RISE0_US    = 300;
    localparam int SS_RISE1_MS    = 10;
    localparam int SS_RISE2_MS    = 20;
    localparam int SS_RISE3_MS    = 40;
    localparam int RIDE_LONG_MS   = 1000;
    localparam int RIDE_SHORT_US  = 128;

endpackage

/* hw/phc_delay.sv */
`timescale 1ns/10ps
`default_nettype none
// output follows the input once it has differed for the selected count
module phc_delay #(
    parameter int W = 32
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         reset,
    // level and counts
    input  wire logic         level_in,
    input  wire logic [W-1:0] rise_cycles,
    input  wire logic [W-1:0] fall_cycles,
    // filtered level
    output logic              level_out
);

    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic         next_level_out;
    logic [W-1:0] target;

    // ------------------------------------------------------------
    // delay counter
    // ------------------------------------------------------------
    // count zero or one both move the output on the first cycle
    always_comb begin
        target         = level_in ? rise_cycles : fall_cycles;
        next_cnt       = '0;
        next_level_out = level_out;
        if (level_in != level_out) begin
            next_cnt = cnt + 1'b1;
            if (next_cnt >= target) begin
                next_level_out = level_in;
                next_cnt       = '0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cnt       <= '0;
            level_out <= 1'b0;
        end else begin
            cnt       <= next_cnt;
            level_out <= next_level_out;
        end
    end

endmodule
`default_nettype wire

/* hw/phc_top.sv */
`timescale 1ns/10ps
`default_nettype none
// What this block does
// R1: pin-5 positive overvoltage: below clears all flags, above sets fault and ov.
// R2: pin-5 positive undervoltage: below reports only uv, above only fault.
// R3: pin-5 negative overvoltage: below reports only ov, above only fault.
// R4: pin-5 negative undervoltage: below clears all, above sets fault and uv.
// R5: supply-on request debounce select: 80 ms, none, 40 ms, 160 ms.
// R6: output-good turn-off delay select: 2 ms, 0 ms, 1 ms, 4 ms.
// R7: current-share capture band select: 1, 2, 3 or 4 percent.
// R8: soft-start rise time select: 300 us, 10 ms, 20 ms, 40 ms.
// R9: lock bit set rejects writes to trim registers, itself included.
// R10: host unlocks by erasing the stored lock bit and reloading.
// R11: overcurrent mask hides trips from logic; status flag still set.
// R12: low polarity bit plus companion bit set power-enable output polarity.
// R13: low polarity bit plus companion bit set breaker output polarity.
// R14: zero-ridethrough bit picks short microsecond periods instead of seconds.
// R15: ground-check disable removes ground input from fault debounce.
// R16: breaker latch bit: 0 non-latching, 1 latching.
// R17: power-up loads both registers from their stored defaults.
// R18: reserved bits 4 to 3 ignore writes and read as zero.
module phc_top #(
    parameter int unsigned CYC_PER_MS = 1000000 / phc_pkg::CLK_PERIOD_NS
) (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // stored defaults
    input  wire logic       ee_load,
    input  wire logic [7:0] ee_cfg4,
    input  wire logic [7:0] ee_cfg5,
    // settings held in neighbouring registers
    input  wire logic [2:0] pin5_function_sel,
    input  wire logic [1:0] pson_debounce_sel,
    input  wire logic [1:0] ridethrough_sel,
    input  wire logic       power_enable_polarity_hi,
    input  wire logic       breaker_polarity_hi,
    // pins from outside the clock domain
    input  wire logic       pin5_above,
    input  wire logic       mains_ok_in,
    input  wire logic       pson_req_in,
    input  wire logic       oc_trip_in,
    input  wire logic       gnd_ok_in,
    // power-management logic
    input  wire logic       pen_request,
    input  wire logic       output_good_in,
    input  wire logic       breaker_clear,
    // results
    output logic            pin5_fault_flag,
    output logic            pin5_ov_flag,
    output logic            pin5_uv_flag,
    output logic            mains_good_output,
    output logic            pson_debounced,
    output logic            output_good_signal,
    output logic      [2:0] share_band_pct,
    output logic            soft_start_busy,
    output logic            oc_status,
    output logic            oc_to_logic,
    output logic            oc_shutdown,
    output logic            pm_fault,
    output logic            power_enable_output,
    output logic            breaker_output,
    output logic            trim_locked
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] ms_cyc(input logic [31:0] ms);
        ms_cyc = ms * CYC_PER_MS;
    endfunction

    function automatic logic [31:0] us_cyc(input logic [31:0] us);
        us_cyc = (us * CYC_PER_MS) / 1000;
    endfunction

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    logic [7:0] cfg4;
    logic [7:0] cfg5;
    logic [7:0] next_cfg4;
    logic [7:0] next_cfg5;
    logic [7:0] next_rdata;
    logic [7:0] status;
    logic       next_trim_locked;
    logic       wr_ok;

    // register writes, lock and power-up load
    always_comb begin
        next_cfg4  = cfg4;
        next_cfg5  = cfg5;
        wr_ok      = reg_wr && !cfg4[phc_pkg::TRIM_LOCK_POS];     // R9
        if (ee_load) begin
            next_cfg4 = ee_cfg4;                                   // R17
            next_cfg5 = ee_cfg5 & phc_pkg::PROT_CFG_WMASK;         // R17
        end else if (wr_ok) begin
            if (reg_addr == phc_pkg::DELAY_SHARE_SOFTSTART_CFG_OFS)
                next_cfg4 = reg_wdata;
            if (reg_addr == phc_pkg::PROTECTION_POLARITY_CFG_OFS)
                next_cfg5 = reg_wdata & phc_pkg::PROT_CFG_WMASK;   // R18
        end
        next_trim_locked = next_cfg4[phc_pkg::TRIM_LOCK_POS];
        next_rdata = reg_rdata;
        if (reg_rd) begin
            case (reg_addr)
                phc_pkg::DELAY_SHARE_SOFTSTART_CFG_OFS: next_rdata = cfg4;
                phc_pkg::PROTECTION_POLARITY_CFG_OFS:   next_rdata = cfg5;
                phc_pkg::HOUSEKEEPING_STATUS_OFS:       next_rdata = status;
                default:                                next_rdata = phc_pkg::RDATA_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cfg4        <= phc_pkg::CFG_RESET;
            cfg5        <= phc_pkg::CFG_RESET;
            reg_rdata   <= phc_pkg::RDATA_UNMAPPED;
            trim_locked <= 1'b0;
        end else begin
            cfg4        <= next_cfg4;
            cfg5        <= next_cfg5;
            reg_rdata   <= next_rdata;
            trim_locked <= next_trim_locked;
        end
    end

    lock_holds_a: assert property (cfg4[phc_pkg::TRIM_LOCK_POS] && reg_wr && !ee_load
        |=> $stable(cfg4) && $stable(cfg5)) else $error("write passed the lock"); // R9
    reserved_zero_a: assert property (reg_wr && !ee_load
        |=> cfg5[4:3] == 2'b00) else $error("reserved bits took a write"); // R18

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [phc_pkg::SYN_W-1:0] syn1;
    logic [phc_pkg::SYN_W-1:0] syn2;
    logic [phc_pkg::SYN_W-1:0] syn3;
    logic [phc_pkg::SYN_W-1:0] pins;
    logic [phc_pkg::SYN_W-1:0] next_pins;
    logic [phc_pkg::SYN_W-1:0] raw_pins;

    // a bit moves once the second and third stage agree
    always_comb begin
        raw_pins = '0;
        raw_pins[phc_pkg::SYN_PIN5]  = pin5_above;
        raw_pins[phc_pkg::SYN_MAINS] = mains_ok_in;
        raw_pins[phc_pkg::SYN_PSON]  = pson_req_in;
        raw_pins[phc_pkg::SYN_OC]    = oc_trip_in;
        raw_pins[phc_pkg::SYN_GND]   = gnd_ok_in;
        next_pins = (syn2 & syn3) | (pins & (syn2 | syn3));
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            syn1 <= '0;
            syn2 <= '0;
            syn3 <= '0;
            pins <= '0;
        end else begin
            syn1 <= raw_pins;
            syn2 <= syn1;
            syn3 <= syn2;
            pins <= next_pins;
        end
    end

    // ------------------------------------------------------------
    // pin-5 threshold compare
    // ------------------------------------------------------------
    logic [2:0] next_flags;
    logic       next_mains_good;
    logic       above;

    // flags ordered fault, ov, uv
    always_comb begin
        above           = pins[phc_pkg::SYN_PIN5];
        next_mains_good = 1'b0;
        case (pin5_function_sel)
            phc_pkg::FN_MAINS_LO: begin
                next_flags      = 3'h0;
                next_mains_good = !pins[phc_pkg::SYN_MAINS];
            end
            phc_pkg::FN_MAINS_HI: begin
                next_flags      = 3'h0;
                next_mains_good = pins[phc_pkg::SYN_MAINS];
            end
            phc_pkg::FN_POS_OV: next_flags = above ? 3'h6 : 3'h0;    // R1
            phc_pkg::FN_POS_UV: next_flags = above ? 3'h4 : 3'h1;    // R2
            phc_pkg::FN_NEG_OV: next_flags = above ? 3'h4 : 3'h2;    // R3
            phc_pkg::FN_NEG_UV: next_flags = above ? 3'h5 : 3'h0;    // R4
            phc_pkg::FN_FLAG:   next_flags = above ? 3'h4 : 3'h0;
            default:            next_flags = 3'h0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pin5_fault_flag   <= 1'b0;
            pin5_ov_flag      <= 1'b0;
            pin5_uv_flag      <= 1'b0;
            mains_good_output <= 1'b0;
        end else begin
            pin5_fault_flag   <= next_flags[2];
            pin5_ov_flag      <= next_flags[1];
            pin5_uv_flag      <= next_flags[0];
            mains_good_output <= next_mains_good;
        end
    end

    pos_ov_a: assert property (pin5_function_sel == phc_pkg::FN_POS_OV
        |=> {pin5_fault_flag, pin5_ov_flag, pin5_uv_flag} == ($past(above) ? 3'h6 : 3'h0))
        else $error("positive overvoltage flags wrong"); // R1
    pos_uv_a: assert property (pin5_function_sel == phc_pkg::FN_POS_UV && !above
        |=> !pin5_fault_flag && !pin5_ov_flag && pin5_uv_flag)
        else $error("positive undervoltage flags wrong"); // R2
    neg_ov_a: assert property (pin5_function_sel == phc_pkg::FN_NEG_OV && above
        |=> pin5_fault_flag && !pin5_ov_flag && !pin5_uv_flag)
        else $error("negative overvoltage flags wrong"); // R3
    neg_uv_a: assert property (pin5_function_sel == phc_pkg::FN_NEG_UV && above
        |=> pin5_fault_flag && !pin5_ov_flag && pin5_uv_flag)
        else $error("negative undervoltage flags wrong"); // R4

    // ------------------------------------------------------------
    // timing selection
    // ------------------------------------------------------------
    logic [31:0] pson_cyc;
    logic [31:0] off_cyc;
    logic [31:0] ss_cyc;
    logic [31:0] ride_cyc;
    logic [31:0] ride_step;

    always_comb begin
        case (pson_debounce_sel)                                         // R5
            2'h0:    pson_cyc = ms_cyc(phc_pkg::PSON_DB0_MS);
            2'h2:    pson_cyc = ms_cyc(phc_pkg::PSON_DB2_MS);
            2'h3:    pson_cyc = ms_cyc(phc_pkg::PSON_DB3_MS);
            default: pson_cyc = '0;
        endcase
        case (cfg4[phc_pkg::OFF_DELAY_LSB +: 2])                         // R6
            2'h0:    off_cyc = ms_cyc(phc_pkg::OFF_WARN0_MS);
            2'h1:    off_cyc = ms_cyc(phc_pkg::OFF_WARN1_MS);
            2'h2:    off_cyc = ms_cyc(phc_pkg::OFF_WARN2_MS);
            default: off_cyc = ms_cyc(phc_pkg::OFF_WARN3_MS);
        endcase
        case (cfg4[phc_pkg::SOFT_START_LSB +: 2])                        // R8
            2'h0:    ss_cyc = us_cyc(phc_pkg::SS_RISE0_US);
            2'h1:    ss_cyc = ms_cyc(phc_pkg::SS_RISE1_MS);
            2'h2:    ss_cyc = ms_cyc(phc_pkg::SS_RISE2_MS);
            default: ss_cyc = ms_cyc(phc_pkg::SS_RISE3_MS);
        endcase
        ride_step = cfg5[phc_pkg::ZERO_RIDE_POS] ? us_cyc(phc_pkg::RIDE_SHORT_US)
                                                 : ms_cyc(phc_pkg::RIDE_LONG_MS); // R14
        ride_cyc  = ride_step * ({30'h0, ridethrough_sel} + 32'h1);
    end

    // ------------------------------------------------------------
    // delay filters
    // ------------------------------------------------------------
    logic ramp_done;
    logic oc_held;

    // supply-on request, both edges filtered
    phc_delay u_pson (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .level_in    (pins[phc_pkg::SYN_PSON]),
        .rise_cycles (pson_cyc),
        .fall_cycles (pson_cyc),
        .level_out   (pson_debounced)
    );

    // output good rises at once and falls after the warning delay
    phc_delay u_off_warn (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .level_in    (output_good_in),
        .rise_cycles (32'h0),
        .fall_cycles (off_cyc),
        .level_out   (output_good_signal)
    );

    // soft-start ramp timer
    phc_delay u_soft_start (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .level_in    (pen_request),
        .rise_cycles (ss_cyc),
        .fall_cycles (32'h0),
        .level_out   (ramp_done)
    );

    // overcurrent ridethrough
    phc_delay u_ride (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .level_in    (oc_to_logic),
        .rise_cycles (ride_cyc),
        .fall_cycles (32'h0),
        .level_out   (oc_held)
    );

    // ------------------------------------------------------------
    // protection and outputs
    // ------------------------------------------------------------
    logic       brk_state;
    logic       next_brk_state;
    logic       next_oc_status;
    logic       next_oc_to_logic;
    logic       next_pm_fault;
    logic       next_pen_out;
    logic       next_brk_out;
    logic       next_ss_busy;
    logic [2:0] next_band;

    always_comb begin
        next_oc_status   = pins[phc_pkg::SYN_OC];                               // R11
        next_oc_to_logic = pins[phc_pkg::SYN_OC] && !cfg5[phc_pkg::OC_MASK_POS]; // R11
        next_pm_fault    = oc_held || (!pins[phc_pkg::SYN_GND]
                           && !cfg5[phc_pkg::GND_DIS_POS]);                     // R15
        // a new trip wins over a clear in the same cycle
        next_brk_state   = oc_held || (cfg5[phc_pkg::BRK_LATCH_POS]
                           && brk_state && !breaker_clear);                     // R16
        next_pen_out     = pen_request ^ cfg5[phc_pkg::PEN_POL_POS]
                           ^ power_enable_polarity_hi;                          // R12
        next_brk_out     = next_brk_state ^ cfg5[phc_pkg::BRK_POL_POS]
                           ^ breaker_polarity_hi;                               // R13
        next_ss_busy     = pen_request && !ramp_done;
        next_band        = {1'b0, cfg4[phc_pkg::SHARE_CAP_LSB +: 2]} + 3'h1;    // R7
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            oc_status           <= 1'b0;
            oc_to_logic         <= 1'b0;
            oc_shutdown         <= 1'b0;
            pm_fault            <= 1'b0;
            brk_state           <= 1'b0;
            power_enable_output <= 1'b0;
            breaker_output      <= 1'b0;
            soft_start_busy     <= 1'b0;
            share_band_pct      <= 3'h1;
        end else begin
            oc_status           <= next_oc_status;
            oc_to_logic         <= next_oc_to_logic;
            oc_shutdown         <= oc_held;
            pm_fault            <= next_pm_fault;
            brk_state           <= next_brk_state;
            power_enable_output <= next_pen_out;
            breaker_output      <= next_brk_out;
            soft_start_busy     <= next_ss_busy;
            share_band_pct      <= next_band;
        end
    end

    // status readback
    assign status = {brk_state, oc_status, pm_fault, soft_start_busy,
                     output_good_signal, pin5_fault_flag, pin5_ov_flag, pin5_uv_flag};

    oc_mask_a: assert property (pins[phc_pkg::SYN_OC] && cfg5[phc_pkg::OC_MASK_POS]
        |=> oc_status && !oc_to_logic) else $error("masked trip reached logic"); // R11
    gnd_off_a: assert property (cfg5[phc_pkg::GND_DIS_POS] && !oc_held
        |=> !pm_fault) else $error("ground input not removed"); // R15
    brk_latch_a: assert property (cfg5[phc_pkg::BRK_LATCH_POS] && brk_state && !breaker_clear
        |=> brk_state) else $error("latched breaker dropped"); // R16

endmodule
`default_nettype wire

/* tb/phc_host.sv */
`timescale 1ns/10ps
`default_nettype none
// host side: register cycles and reloads of the stored copy
module phc_host (
    // clock
    input  wire logic       sys_clk,
    // register port
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata,
    // stored copy
    output logic            ee_load,
    output logic      [7:0] ee_cfg4,
    output logic      [7:0] ee_cfg5
);
    // idle at time zero
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, ee_load, ee_cfg4, ee_cfg5} = '0;
    end
    // write held for one edge; lines inverted once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge sys_clk);
        {reg_addr, reg_wdata, reg_wr} <= {~a, ~d, 1'b0};
    endtask
    // read; data taken after the registered answer settles
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge sys_clk);
        {reg_addr, reg_rd} <= {~a, 1'b0};
        @(posedge sys_clk);
        #1;
        d = reg_rdata;
    endtask
    // reload as at power-up; unlocking means a cleared lock bit here
    task automatic load(input logic [7:0] c4, input logic [7:0] c5);
        @(posedge sys_clk);
        {ee_cfg4, ee_cfg5, ee_load} <= {c4, c5, 1'b1};
        @(posedge sys_clk);
        {ee_cfg4, ee_cfg5, ee_load} <= {~c4, ~c5, 1'b0};
    endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
    // ------------------------------------------------------------
    // stimulus and observed outputs
    // ------------------------------------------------------------
    logic       sys_clk = 1'b0;
    logic       reset = 1'b1;
    logic [2:0] fn_sel = 3'h0;
    logic       above = 1'b0, oc = 1'b0, gnd = 1'b1, pen_pol = 1'b0;
    logic       pen_req = 1'b0, og_in = 1'b0, brk_clr = 1'b0, pson = 1'b0;
    logic [7:0] addr, wdata, c4, c5, rdata, rd_val;
    logic       wr, rd, ld;
    wire  [2:0] flags, band;
    wire        oc_st, oc_lg, pmf, pen_o, og_o, locked, pson_o, ss_o, oc_sd, brk_o;
    int         n_fail = 0, cmp_count = 0;
    // host model and device
    phc_host i_host (.sys_clk(sys_clk), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata(rdata), .ee_load(ld), .ee_cfg4(c4), .ee_cfg5(c5));
    phc_top #(.CYC_PER_MS(10)) i_dut (.sys_clk(sys_clk), .reset(reset), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .ee_load(ld),
        .ee_cfg4(c4), .ee_cfg5(c5), .pin5_function_sel(fn_sel), .pson_debounce_sel(2'h2),
        .ridethrough_sel(2'h1), .power_enable_polarity_hi(pen_pol), .breaker_polarity_hi(1'b0),
        .pin5_above(above), .mains_ok_in(1'b1), .pson_req_in(pson), .oc_trip_in(oc),
        .gnd_ok_in(gnd), .pen_request(pen_req), .output_good_in(og_in),
        .breaker_clear(brk_clr), .pin5_fault_flag(flags[2]), .pin5_ov_flag(flags[1]),
        .pin5_uv_flag(flags[0]), .mains_good_output(), .pson_debounced(pson_o),
        .output_good_signal(og_o), .share_band_pct(band), .soft_start_busy(ss_o),
        .oc_status(oc_st), .oc_to_logic(oc_lg), .oc_shutdown(oc_sd), .pm_fault(pmf),
        .power_enable_output(pen_o), .breaker_output(brk_o), .trim_locked(locked));
    // clock
    initial forever #5 sys_clk = ~sys_clk;
    // wait n edges, then let their updates land
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // read one register and compare
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        i_host.rd(a, rd_val);
        `CHK(rd_val, e)
    endtask
    // pin-5 comparator case, past the synchroniser
    task automatic pin5(input logic [2:0] f, input logic a, input logic [2:0] e);
        @(posedge sys_clk);
        {fn_sel, above} <= {f, a};
        cyc(8);
        `CHK(flags, e)
    endtask
    // overcurrent mask and ground-check disable
    task automatic t_oc();
        i_host.load(8'h00, 8'h80);
        @(posedge sys_clk);
        oc <= 1'b1;
        cyc(8);
        `CHK({oc_st, oc_lg}, 2'h2)
        i_host.wr(8'h11, 8'h00);
        cyc(3);
        `CHK(oc_lg, 1'b1)
        @(posedge sys_clk);
        {oc, brk_clr, gnd} <= 3'h2;
        cyc(8);
        `CHK(pmf, 1'b1)
        i_host.wr(8'h11, 8'h02);
        cyc(3);
        `CHK(pmf, 1'b0)
    endtask
    // power-enable polarity from both bits
    task automatic t_pen();
        @(posedge sys_clk);
        pen_req <= 1'b1;
        cyc(2);
        `CHK(pen_o, 1'b1)
        @(posedge sys_clk);
        pen_pol <= 1'b1;
        cyc(2);
        `CHK(pen_o, 1'b0)
        i_host.wr(8'h11, 8'h40);
        cyc(2);
        `CHK(pen_o, 1'b1)
    endtask
    // output-good turn-off delay, 4 ms is 40 cycles here
    task automatic t_off(input logic [7:0] v, input int hold, input int rest);
        i_host.wr(8'h10, v);
        @(posedge sys_clk);
        og_in <= 1'b1;
        repeat (3) @(posedge sys_clk);
        og_in <= 1'b0;
        cyc(hold);
        `CHK(og_o, hold > 5)
        cyc(rest);
        `CHK(og_o, 1'b0)
    endtask
    // soft-start ramp, 10 ms is 100 cycles here
    task automatic t_ss();
        i_host.wr(8'h10, 8'h04);
        @(posedge sys_clk);
        pen_req <= 1'b0;
        repeat (2) @(posedge sys_clk);
        pen_req <= 1'b1;
        cyc(50);
        `CHK(ss_o, 1'b1)
        cyc(60);
        `CHK(ss_o, 1'b0)
    endtask
    // supply-on request debounce, 40 ms is 400 cycles here
    task automatic t_pson();
        @(posedge sys_clk);
        pson <= 1'b1;
        cyc(300);
        `CHK(pson_o, 1'b0)
        cyc(120);
        `CHK(pson_o, 1'b1)
    endtask
    // short ridethrough trip, latched breaker, then clear
    task automatic t_trip();
        i_host.wr(8'h11, 8'h05);
        @(posedge sys_clk);
        {oc, brk_clr} <= 2'h2;
        cyc(10);
        `CHK({oc_sd, brk_o}, 2'h3)
        @(posedge sys_clk);
        oc <= 1'b0;
        cyc(8);
        `CHK({oc_sd, brk_o}, 2'h1)
        @(posedge sys_clk);
        brk_clr <= 1'b1;
        cyc(2);
        `CHK(brk_o, 1'b0)
    endtask
    // ------------------------------------------------------------
    // verdict
    // ------------------------------------------------------------
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // watchdog on the whole run
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        close_out();
    end
    // main sequence
    initial begin
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        rd_chk(8'h10, 8'h00);
        i_host.load(8'hc2, 8'hff);
        rd_chk(8'h10, 8'hc2);
        rd_chk(8'h11, 8'he7);
        i_host.wr(8'h11, 8'h18);
        rd_chk(8'h11, 8'h00);
        rd_chk(8'h20, 8'h00);
        pin5(3'h2, 1'b0, 3'h0);
        pin5(3'h2, 1'b1, 3'h6);
        pin5(3'h3, 1'b0, 3'h1);
        pin5(3'h3, 1'b1, 3'h4);
        pin5(3'h4, 1'b0, 3'h2);
        pin5(3'h4, 1'b1, 3'h4);
        pin5(3'h5, 1'b0, 3'h0);
        pin5(3'h5, 1'b1, 3'h5);
        for (int i = 0; i < 4; i++) begin
            i_host.wr(8'h10, 8'(i << 4));
            cyc(2);
            `CHK(band, 3'(i + 1))
        end
        t_oc();
        t_pen();
        t_off(8'hc0, 35, 10);
        t_off(8'h40, 3, 1);
        t_ss();
        t_pson();
        i_host.wr(8'h10, 8'h01);
        cyc(1);
        `CHK(locked, 1'b1)
        i_host.wr(8'h10, 8'h00);
        rd_chk(8'h10, 8'h01);
        i_host.wr(8'h11, 8'h21);
        rd_chk(8'h11, 8'h40);
        i_host.load(8'h00, 8'h00);
        i_host.wr(8'h11, 8'h21);
        rd_chk(8'h11, 8'h21);
        `CHK(brk_o, 1'b1)
        t_trip();
        close_out();
    end
endmodule
`default_nettype wire
